// ---- src/pid_regs.svh ----
/*
  register offsets, field positions, reset values and timing counts
  of the island-mode pid regulator.
  assumes a 100 MHz pclk and an apb slave decoding paddr[7:0].
*/
`ifndef PID_REGS_SVH
`define PID_REGS_SVH
`define CTRL_OFS     8'h00
`define STATUS_OFS   8'h04
`define MASK_OFS     8'h08
`define DELAY_OFS    8'h0C
`define STATE_OFS    8'h10
`define GOV_OUT_OFS  8'h14
`define AVR_OUT_OFS  8'h18
`define CH_BASE      8'h20
`define CH_STRIDE    8'h20
// fields inside a channel block, word index
`define F_KP  3'h0
`define F_TI  3'h1
`define F_TD  3'h2
`define F_DB  3'h3
`define F_RKP 3'h4
`define F_NOM 3'h5
`define F_LIM 3'h6
`define F_OFS 3'h7
// ctrl bits
`define CTRL_EN    0
`define CTRL_RELAY 1
`define CTRL_ALEN  2
// status bits
`define ST_DLY  0
`define ST_GSAT 1
`define ST_ASAT 2
// reset values and limits; kp, ti and td in hundredths, delay in seconds, bands in tenths of %
`define KP_RST     16'h00FA
`define TI_RST     16'h0096
`define TD_RST     16'h0000
`define GDB_RST    16'h000A
`define ADB_RST    16'h0014
`define RKP_RST    16'h000A
`define NOM_RST    16'h1000
`define LIM_RST    16'h0800
`define OFS_RST    16'h0000
`define DELAY_RST  14'h0003
`define DELAY_MAX  14'h26AC
`define KP_MAX     16'h1770
`define TD_MAX     16'h00C8
`define GDB_MIN    16'h0002
`define DB_MAX     16'h0064
`define RKP_MAX    16'h0064
// timing
`define CLK_MHZ    100
`define SAMPLE_MS  10
`define SAMPLE_CYC (`SAMPLE_MS * `CLK_MHZ * 1000)
`define SEC_CYC    (`CLK_MHZ * 1000000)
`define TS_HUND    (`SAMPLE_MS / 10)
`endif

// ---- src/pid_pkg.sv ----
/*
  types of the island-mode pid regulator.
  assumes pid_regs.svh supplies the numeric constants.
*/
package pid_pkg;
  // per-loop tuning set
  typedef struct packed {
    logic [15:0] kp;
    logic [15:0] ti;
    logic [15:0] td;
    logic [15:0] db;
    logic [15:0] rkp;
    logic [15:0] nom;
    logic [15:0] lim;
    logic [15:0] ofs;
  } pid_cfg_t;
  // controller family chosen by breaker positions
  typedef enum logic [1:0] {
    LOOP_IDLE   = 2'b00,
    LOOP_ISLAND = 2'b01,
    LOOP_SHARE  = 2'b10,
    LOOP_GRID   = 2'b11
  } loop_sel_t;
  // regulation delay sequence
  typedef enum logic [1:0] {
    DLY_IDLE = 2'b00,
    DLY_WAIT = 2'b01,
    DLY_RUN  = 2'b10
  } dly_state_t;
endpackage

// ---- src/pid_regulator_island_mode.sv ----
/*
  island-mode pid regulator for governor and voltage regulator bias,
  with apb registers, regulation delay timer and interrupt.
  assumes measurements come from logic on pclk; breaker and run pins
  are asynchronous. load-share and grid loops live elsewhere: here the
  outputs simply stay at offset while those loops are selected.
*/
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pid_regs.svh"
module pid_regulator_island_mode #(
  parameter int SAMPLE_CYC = `SAMPLE_CYC,
  parameter int SEC_CYC    = `SEC_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] freq_meas,
  input  wire logic [15:0] volt_meas,
  input  wire logic        running_in,
  input  wire logic        breaker_closed_in,
  input  wire logic        grid_parallel_in,
  output logic [15:0]      gov_bias,
  output logic [15:0]      avr_bias,
  output logic             delay_active,
  output logic             delay_alarm,
  output logic             irq
);

  // only the island family regulates here; share and grid are
  // recognised so that the outputs can park at offset for them
  // loop family from breaker positions
  function automatic pid_pkg::loop_sel_t loop_pick(input logic run,
                                                   input logic brk,
                                                   input logic par);
    if (!run) begin
      loop_pick = pid_pkg::LOOP_IDLE;
    end else if (!brk) begin
      loop_pick = pid_pkg::LOOP_ISLAND;
    end else if (!par) begin
      loop_pick = pid_pkg::LOOP_SHARE;
    end else begin
      loop_pick = pid_pkg::LOOP_GRID;
    end
  endfunction

  // used for kp, ti, td, db and rkp, so software cannot store a value
  // that the regulator would misread
  // clamp a 16-bit field into its legal range
  function automatic logic [15:0] fit(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
    fit = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // state of the block first, combinational helpers after it
  pid_pkg::pid_cfg_t    cfg_q [2];     // tuning, 0 governor, 1 avr
  logic [2:0]           ctrl_q;        // enable, relay, alarm enable
  logic [2:0]           status_q;      // sticky events
  logic [2:0]           mask_q;        // interrupt mask
  logic [13:0]          delay_q;       // regulation delay in seconds
  logic [2:0]           sync1_q;       // first synchroniser stage
  logic [2:0]           sync2_q;       // second stage, safe to read
  pid_pkg::dly_state_t  dly_q;         // delay sequence
  logic [31:0]          cyc_cnt_q;     // cycles inside one second
  logic [13:0]          sec_cnt_q;     // elapsed delay seconds
  logic [31:0]          tick_cnt_q;    // sample divider
  logic                 tick_q;        // one-cycle sample enable
  logic [15:0]          bias_q [2];    // outputs
  logic [1:0]           sat_q;         // output at a limit
  logic [1:0]           sat_ev;        // saturation onset
  logic                 dly_ev;        // delay expiry
  logic                 wr_en;         // apb write strobe
  logic [31:0]          rd_d;          // read mux
  logic                 err_d;         // unmapped address
  logic [15:0]          meas [2];      // selected measurement
  pid_pkg::loop_sel_t   loop_sel;      // current loop family
  logic                 reg_on;        // island regulation allowed

  // apb has no wait states: pready follows the access phase
  // irq is a level, so software clears status before unmasking
  assign wr_en    = psel & penable & pwrite;
  assign pready   = psel & penable;
  assign meas[0]  = freq_meas;
  assign meas[1]  = volt_meas;
  assign loop_sel = loop_pick(sync2_q[0], sync2_q[1], sync2_q[2]);
  assign delay_active = (dly_q == pid_pkg::DLY_WAIT);
  assign reg_on   = ctrl_q[`CTRL_EN] & (loop_sel == pid_pkg::LOOP_ISLAND) &
                    (dly_q == pid_pkg::DLY_RUN);
  assign delay_alarm = delay_active & ctrl_q[`CTRL_ALEN];
  assign irq      = |(status_q & mask_q);
  assign gov_bias = bias_q[0];
  assign avr_bias = bias_q[1];
  assign dly_ev   = (dly_q == pid_pkg::DLY_WAIT) && sync2_q[0] &&
                    (sec_cnt_q >= delay_q);

  // the pins come from the engine panel with no relation to pclk;
  // nothing reads sync1_q but the second stage
  // pin synchronisers: run, breaker closed, grid parallel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {grid_parallel_in, breaker_closed_in, running_in};
      sync2_q <= sync1_q;
    end
  end

  // a write to a read-only address is simply dropped; one to an unmapped address is dropped with pslverr
  // register writes; out-of-range values are pulled into range, except lim, which only drops bit 15
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= 3'h1;
      mask_q  <= 3'h0;
      delay_q <= `DELAY_RST;
      for (int c = 0; c < 2; c++) begin
        cfg_q[c].kp  <= `KP_RST;
        cfg_q[c].ti  <= `TI_RST;
        cfg_q[c].td  <= `TD_RST;
        cfg_q[c].db  <= (c == 0) ? `GDB_RST : `ADB_RST;
        cfg_q[c].rkp <= `RKP_RST;
        cfg_q[c].nom <= `NOM_RST;
        cfg_q[c].lim <= `LIM_RST;
        cfg_q[c].ofs <= `OFS_RST;
      end
    end else if (wr_en) begin
      case (paddr)
        `CTRL_OFS: begin
          ctrl_q <= pwdata[2:0];
        end
        `MASK_OFS: begin
          mask_q <= pwdata[2:0];
        end
        `DELAY_OFS: begin
          delay_q <= (pwdata[13:0] > `DELAY_MAX) ? `DELAY_MAX : pwdata[13:0];
        end
        default: begin
          for (int c = 0; c < 2; c++) begin
            if (paddr[7:5] == 3'(c + 1) && paddr[1:0] == 2'h0) begin
              case (paddr[4:2])
                `F_KP:  cfg_q[c].kp  <= fit(pwdata[15:0], 16'h0000, `KP_MAX);
                `F_TI:  cfg_q[c].ti  <= fit(pwdata[15:0], 16'h0000, `KP_MAX);
                `F_TD:  cfg_q[c].td  <= fit(pwdata[15:0], 16'h0000, `TD_MAX);
                `F_DB:  cfg_q[c].db  <= fit(pwdata[15:0],
                                            (c == 0) ? `GDB_MIN : 16'h0000,
                                            `DB_MAX);
                `F_RKP: cfg_q[c].rkp <= fit(pwdata[15:0], 16'h0000, `RKP_MAX);
                `F_NOM: cfg_q[c].nom <= pwdata[15:0];
                `F_LIM: cfg_q[c].lim <= {1'b0, pwdata[14:0]};
                default: cfg_q[c].ofs <= pwdata[15:0];
              endcase
            end
          end
        end
      endcase
    end
  end

  // setting and clearing in one cycle keeps the event, so no
  // saturation or expiry is lost to a late clear
  // sticky status; a new event beats a simultaneous clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~((wr_en && paddr == `STATUS_OFS) ? pwdata[2:0] : 3'h0)) |
                  {sat_ev, dly_ev};
    end
  end

  // cycles and seconds are counted apart: a 9900 s delay in raw
  // cycles would need a far wider counter
  // dropping running at any point restarts the whole sequence
  // regulation delay: starts once running is detected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_q     <= pid_pkg::DLY_IDLE;
      cyc_cnt_q <= 32'h0;
      sec_cnt_q <= 14'h0;
    end else begin
      case (dly_q)
        pid_pkg::DLY_IDLE: begin
          cyc_cnt_q <= 32'h0;
          sec_cnt_q <= 14'h0;
          if (sync2_q[0]) begin
            dly_q <= pid_pkg::DLY_WAIT;
          end
        end
        pid_pkg::DLY_WAIT: begin
          if (!sync2_q[0]) begin
            dly_q <= pid_pkg::DLY_IDLE;
          end else if (sec_cnt_q >= delay_q) begin
            dly_q <= pid_pkg::DLY_RUN;
          end else if (cyc_cnt_q == 32'(SEC_CYC - 1)) begin
            cyc_cnt_q <= 32'h0;
            sec_cnt_q <= sec_cnt_q + 14'h1;
          end else begin
            cyc_cnt_q <= cyc_cnt_q + 32'h1;
          end
        end
        pid_pkg::DLY_RUN: begin
          if (!sync2_q[0]) begin
            dly_q <= pid_pkg::DLY_IDLE;
          end
        end
        default: begin
          dly_q <= pid_pkg::DLY_IDLE;
        end
      endcase
    end
  end

  // the sample period scales both the integral and the slope;
  // changing SAMPLE_CYC without TS_HUND detunes the loop
  // sample tick divider; the whole loop moves only on this pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(SAMPLE_CYC - 1)) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // fixed point: gain and times in hundredths, output in counts;
  // 48 bits hold the worst product of gain, td and a full swing
  // one regulator per loop; wide math keeps gain*td*slope exact
  for (genvar g = 0; g < 2; g++) begin : gen_loop
    logic signed [47:0] acc_q;   // integral, hundredths of output
    logic signed [16:0] eprev_q; // previous deviation
    logic signed [16:0] err;     // nominal minus measured
    logic signed [47:0] kp_s;
    logic signed [47:0] p_t;
    logic signed [47:0] i_inc;
    logic signed [47:0] d_t;
    logic signed [47:0] band;
    logic signed [47:0] sum_t;
    logic signed [47:0] lim_s;
    logic signed [47:0] clip;
    logic               sat_d;

    // deviation is positive while the set runs below nominal
    assign err = $signed({1'b0, cfg_q[g].nom}) - $signed({1'b0, meas[g]});

    // combine the three parts, or the relay response
    always_comb begin
      kp_s  = 48'($signed({1'b0, cfg_q[g].kp}));
      lim_s = 48'($signed({1'b0, cfg_q[g].lim}));
      p_t   = (kp_s * 48'(err)) / 48'sh64;
      // per tick: gain*e*ts/ti, so a full ti repeats the p step
      i_inc = (cfg_q[g].ti == 16'h0) ? 48'sh0 :
              (kp_s * 48'(err) * 48'(`TS_HUND)) /
              48'($signed({1'b0, cfg_q[g].ti}));
      d_t   = (cfg_q[g].td == 16'h0) ? 48'sh0 :
              (kp_s * 48'($signed({1'b0, cfg_q[g].td})) * 48'(err - eprev_q)) /
              (48'sh64 * 48'(`TS_HUND));
      band  = 48'($signed({1'b0, cfg_q[g].nom})) *
              48'($signed({1'b0, cfg_q[g].db})) / 48'sh3E8;
      // relay mode replaces the whole sum; no memory is kept
      if (ctrl_q[`CTRL_RELAY]) begin
        sum_t = (48'(err) <= band && 48'(err) >= -band) ? 48'sh0 :
                48'($signed({1'b0, cfg_q[g].rkp})) * 48'(err);
      end else begin
        sum_t = p_t + (acc_q / 48'sh64) + d_t;
      end
      sat_d = (sum_t > lim_s) || (sum_t < -lim_s);
      clip  = (sum_t > lim_s) ? lim_s : ((sum_t < -lim_s) ? -lim_s : sum_t);
    end

    // the integral is frozen on a saturating tick to stop windup
    // sample update; outside regulation hold the offset
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_q     <= 48'sh0;
        eprev_q   <= 17'sh0;
        bias_q[g] <= `OFS_RST;
        sat_q[g]  <= 1'b0;
      end else if (!reg_on) begin
        acc_q     <= 48'sh0;
        eprev_q   <= err;
        bias_q[g] <= cfg_q[g].ofs;
        sat_q[g]  <= 1'b0;
      end else if (tick_q) begin
        eprev_q   <= err;
        bias_q[g] <= cfg_q[g].ofs + clip[15:0];
        sat_q[g]  <= sat_d;
        if (cfg_q[g].ti == 16'h0 || ctrl_q[`CTRL_RELAY]) begin
          acc_q <= 48'sh0;
        end else if (!sat_d) begin
          acc_q <= acc_q + i_inc;
        end
      end
    end

    assign sat_ev[g] = tick_q & reg_on & sat_d & ~sat_q[g];
  end

  // reads have no side effects; status clears only by a write
  // read mux and address check
  always_comb begin
    rd_d  = 32'h0;
    err_d = 1'b0;
    case (paddr)
      `CTRL_OFS:    rd_d = {29'h0, ctrl_q};
      `STATUS_OFS:  rd_d = {29'h0, status_q};
      `MASK_OFS:    rd_d = {29'h0, mask_q};
      `DELAY_OFS:   rd_d = {18'h0, delay_q};
      `STATE_OFS:   rd_d = {24'h0, sat_q, dly_q, loop_sel, reg_on, delay_alarm};
      `GOV_OUT_OFS: rd_d = {16'h0, bias_q[0]};
      `AVR_OUT_OFS: rd_d = {16'h0, bias_q[1]};
      default: begin
        if ((paddr[7:5] == 3'h1 || paddr[7:5] == 3'h2) && paddr[1:0] == 2'h0) begin
          rd_d = {16'h0, cfg_q[paddr[6]][(7 - paddr[4:2]) * 16 +: 16]};
        end else begin
          err_d = 1'b1;
        end
      end
    endcase
  end

  // a write returns zero so stale data never reaches the bus
  // read data captured in the setup cycle, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0 : rd_d;
      pslverr <= err_d;
    end
  end

endmodule
`default_nettype wire

// ---- dv/pid_sensor.sv ----
/*
  far-side model: frequency and voltage meters of the set.
  assumes the bench sets the plant values on pclk edges.
*/
`timescale 1ns/10ps
`default_nettype none
module pid_sensor (
  input  wire logic        pclk,
  input  wire logic [15:0] fset,
  input  wire logic [15:0] vset,
  output logic [15:0]      freq_meas,
  output logic [15:0]      volt_meas
);
  // one-cycle sample delay, as a real meter never answers at once
  always_ff @(posedge pclk) begin
    freq_meas <= fset;
    volt_meas <= vset;
  end
endmodule
`default_nettype wire

// ---- dv/pid_regulator_sva.sv ----
/*
  port checker of the island pid regulator.
  assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pid_regs.svh"
module pid_regulator_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        running_in,
  input wire logic        breaker_closed_in,
  input wire logic [15:0] gov_bias,
  input wire logic [15:0] avr_bias,
  input wire logic        delay_active,
  input wire logic        delay_alarm,
  input wire logic        irq
);
  // a write that masks every interrupt source
  wire logic mask_clr = psel && penable && pwrite && paddr == `MASK_OFS && pwdata[2:0] == 3'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready not zero wait");
  a_alarm_in_delay: assert property (delay_alarm |-> delay_active)
    else $error("alarm outside delay");
  a_delay_after_run: assert property ($rose(delay_active) |-> $past(running_in, 2))
    else $error("delay without running");
  a_bias_hold_delay: assert property (delay_active && $past(delay_active) |-> $stable(gov_bias) && $stable(avr_bias))
    else $error("bias moved during delay");
  a_share_at_offset: assert property (breaker_closed_in [*6] |=> $stable(gov_bias) && $stable(avr_bias))
    else $error("bias moved with breaker closed");
  a_irq_masked_off: assert property ($past(mask_clr) |-> !irq)
    else $error("irq with all masked");
  a_err_read_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_ctrl_is_mapped: assert property (psel && penable && paddr == `CTRL_OFS |-> !pslverr)
    else $error("ctrl refused");
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
/*
  self-checking bench of the island pid regulator.
  assumes pid_sensor and pid_regulator_sva; counts are shortened.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pid_regs.svh"
module testbench;
  localparam int SC  = 20;   // sample period in cycles
  localparam int SEC = 50;   // one second in cycles
  localparam int NOM = 4096; // nominal after reset
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, delay_active, delay_alarm, irq;
  logic        running_in = 0, breaker_closed_in = 0, grid_parallel_in = 0;
  logic [15:0] fset = 16'h1000, vset = 16'h1000, freq_meas, volt_meas, gov_bias, avr_bias, prev;
  logic [15:0] rst_tab [8] = '{`KP_RST, `TI_RST, `TD_RST, `GDB_RST, `RKP_RST, `NOM_RST, `LIM_RST, `OFS_RST};
  int          fails = 0, samples_checked = 0, ofs, e, n, i, a;
  always #5 pclk = ~pclk;
  pid_sensor sens (.pclk(pclk), .fset(fset), .vset(vset), .freq_meas(freq_meas), .volt_meas(volt_meas));
  pid_regulator_island_mode #(.SAMPLE_CYC(SC), .SEC_CYC(SEC)) uut (.*);
  // word address of a channel field
  function automatic logic [7:0] fa(input int ch, input int f);
    return 8'(`CH_BASE + ch * `CH_STRIDE + f * 4);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task chkb(input logic [15:0] got, input int exp);
    chk({16'h0, got}, {16'h0, 16'(exp)});
  endtask
  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no bound of its own: pready high, or else the watchdog, ends this wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task rdc(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask
  // plant values seen by the meters, given as deviations
  task pin(input int ef, input int ev);
    @(posedge pclk);
    fset <= 16'(NOM - ef);
    vset <= 16'(NOM - ev);
  endtask
  // let whole sample periods pass, then look at settled outputs
  task go(input int k);
    repeat (k * SC) @(posedge pclk);
    #1;
  endtask
  // bounded wait for the next change of the governor bias
  task wchg;
    #1;
    prev = gov_bias;
    n = 0;
    while (gov_bias === prev && n < 3 * SC) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // run is under two thousand cycles; this only cuts a hang
  initial begin
    #400000;
    fails++;
    summarize;
  end
  initial begin
    void'($urandom(32'h7AF3A70D));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rdc(fa(0, i), {16'h0, rst_tab[i]});
    end
    rdc(fa(1, 3), {16'h0, `ADB_RST});
    rdc(`DELAY_OFS, {18'h0, `DELAY_RST});
    rdc(`CTRL_OFS, 32'h1);
    wr(fa(0, 0), 32'hFFFF);
    rdc(fa(0, 0), {16'h0, `KP_MAX});
    wr(fa(0, 2), 32'h12C);
    rdc(fa(0, 2), {16'h0, `TD_MAX});
    wr(fa(0, 3), 32'h1);
    rdc(fa(0, 3), {16'h0, `GDB_MIN});
    wr(`DELAY_OFS, 32'h3FFF);
    rdc(`DELAY_OFS, {18'h0, `DELAY_MAX});
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    ofs = $urandom % 16384;
    for (i = 0; i < 2; i++) begin
      wr(fa(i, 0), 32'hC8);
      wr(fa(i, 1), 32'h0);
      wr(fa(i, 2), 32'h0);
    end
    wr(fa(0, 3), 32'hA);
    wr(fa(0, 7), 32'(ofs));
    // start twice: 3 s with alarm off and masked, 1 s with both on
    for (i = 0; i < 2; i++) begin
      wr(`CTRL_OFS, i ? 32'h5 : 32'h1);
      wr(`MASK_OFS, 32'(i));
      wr(`DELAY_OFS, 32'(3 - 2 * i));
      @(posedge pclk);
      running_in <= 1'b1;
      n = 0;
      while (delay_active !== 1'b1 && n < 10) begin
        @(posedge pclk);
        #1;
        n++;
      end
      a = 0;
      while (delay_active === 1'b1 && a < 400) begin
        chk1(delay_alarm, i[0]);
        chkb(gov_bias, ofs);
        @(posedge pclk);
        #1;
        a++;
      end
      chk1(a >= (3 - 2 * i) * SEC - 3 && a <= (3 - 2 * i) * SEC + 3, 1'b1);
      rdc(`STATUS_OFS, 32'h1);
      chk1(irq, i[0]);
      wr(`MASK_OFS, 32'h1);
      chk1(irq, 1'b1);
      wr(`STATUS_OFS, 32'h1);
      chk1(irq, 1'b0);
      @(posedge pclk);
      running_in <= 1'(i);
      repeat (4) @(posedge pclk);
    end
    e = $urandom % 512;
    pin(e, 50);
    go(2);
    chkb(gov_bias, ofs + 2 * e);
    chkb(avr_bias, 100);
    pin(2 * e, 50);
    go(2);
    chkb(gov_bias, ofs + 4 * e);
    pin(100, 50);
    wr(fa(0, 2), 32'hA);
    go(2);
    chkb(gov_bias, ofs + 200);
    pin(150, 50);
    wchg;
    chkb(gov_bias, ofs + 1300);
    go(1);
    chkb(gov_bias, ofs + 300);
    wr(fa(0, 2), 32'h32);
    pin(100, 50);
    wchg;
    chkb(gov_bias, ofs - 2048);
    rdc(`STATUS_OFS, 32'h2);
    wr(fa(0, 2), 32'h0);
    pin(150, 50);
    wchg;
    chkb(gov_bias, ofs + 300);
    pin(100, 50);
    wr(fa(0, 1), 32'h14);
    go(2);
    a = int'(gov_bias);
    go(20);
    chkb(gov_bias, a + 200);
    wr(fa(0, 1), 32'hA);
    go(1);
    a = int'(gov_bias);
    go(1);
    chkb(gov_bias, a + 20);
    apb(1'b0, `STATE_OFS, 32'h0);
    chk(32'(rd[3:2]), 32'h1);
    wr(`CTRL_OFS, 32'h3);
    pin(40, 81);
    go(2);
    chkb(gov_bias, ofs);
    chkb(avr_bias, 0);
    pin(41, 82);
    go(2);
    chkb(gov_bias, ofs + 410);
    chkb(avr_bias, 820);
    @(posedge pclk);
    breaker_closed_in <= 1'b1;
    go(1);
    chkb(gov_bias, ofs);
    chkb(avr_bias, 0);
    @(posedge pclk);
    grid_parallel_in <= 1'b1;
    go(1);
    apb(1'b0, `STATE_OFS, 32'h0);
    chk(32'(rd[3:2]), 32'h3);
    summarize;
  end
endmodule
bind pid_regulator_island_mode pid_regulator_sva sva_i (
  .pclk              (pclk),
  .presetn           (presetn),
  .psel              (psel),
  .penable           (penable),
  .pwrite            (pwrite),
  .paddr             (paddr),
  .pwdata            (pwdata),
  .prdata            (prdata),
  .pready            (pready),
  .pslverr           (pslverr),
  .running_in        (running_in),
  .breaker_closed_in (breaker_closed_in),
  .gov_bias          (gov_bias),
  .avr_bias          (avr_bias),
  .delay_active      (delay_active),
  .delay_alarm       (delay_alarm),
  .irq               (irq)
);
`default_nettype wire
